// ---- design/monitor_defs.svh ----
// Offsets, field positions, reset values and timing counts of the monitor readout.
// Assumes inclusion by bare name from the package and the design modules.
`ifndef MONITOR_DEFS_SVH
`define MONITOR_DEFS_SVH

// Channels: 0 temperature, 1 supply, 2..4 external inputs a..c
`define NUM_CH 5
`define CHAN_TEMP 3'h0
`define CHAN_LAST 3'h4
`define RESULT_W 16
`define LIMIT_DEPTH 20

// Limit kinds, also the flag group index inside the event layout
`define LIM_ALARM_HI 2'h0
`define LIM_ALARM_LO 2'h1
`define LIM_WARN_HI 2'h2
`define LIM_WARN_LO 2'h3

// Register byte addresses on the Avalon slave
`define REG_CTRL 8'h00
`define REG_STATUS 8'h04
`define REG_MASK 8'h08
`define REG_LIVE 8'h0C
`define REG_RESULT_FIRST 8'h10
`define REG_RESULT_LAST 8'h20
`define REG_LIMIT_FIRST 8'h40
`define REG_LIMIT_LAST 8'h8C

// Reset values
`define CTRL_RESET 4'h1
`define EVENT_RESET 25'h0000000

// Reduced-resolution variant clears this many low result bits
`define LOW_RES_BITS 3
`define SERIAL_BITS 5'h10

// Timing: one full round of all channels per frame time
`define FRAME_TIME_MS 30
`define CLK_FREQ_HZ 100000000
`define SLOT_CYCLES ((`FRAME_TIME_MS * (`CLK_FREQ_HZ / 1000)) / `NUM_CH)

`endif

// ---- design/monitor_pkg.sv ----
// Types shared by the monitor readout modules.
// Assumes monitor_defs.svh is on the include path.
`include "monitor_defs.svh"

package monitor_pkg;

    typedef struct packed {
        logic protect_en;
        logic fault_out_en;
        logic low_res;
        logic run;
    } ctrl_t;

    // Flag groups indexed by limit kind, each one bit per channel
    typedef struct packed {
        logic [3:0][`NUM_CH-1:0] flag;
        logic [`NUM_CH-1:0] done;
    } event_t;

    typedef enum logic [1:0] {
        BUS_IDLE = 2'b00,
        BUS_MEM = 2'b01,
        BUS_ACK = 2'b10
    } bus_state_t;

    typedef enum logic [0:0] {
        CHK_IDLE = 1'b0,
        CHK_RUN = 1'b1
    } chk_state_t;

endpackage

// ---- design/limit_ram.sv ----
// Limit store: four 16-bit limits per channel, byte-writable, registered read.
// Assumes one access per cycle; the caller arbitrates between users.
`include "monitor_defs.svh"

module limit_ram (
    // Clock and control
    input wire logic clk_sys_i,
    input wire logic rst_i,
    input wire logic ce_i,
    // Access port
    input wire logic en_i,
    input wire logic we_i,
    input wire logic [1:0] be_i,
    input wire logic [4:0] addr_i,
    input wire logic [15:0] wdata_i,
    output logic [15:0] rdata_o
);

    logic [15:0] mem [`LIMIT_DEPTH];

    // Limits default to zero, like a blank store
    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            for (int i = 0; i < `LIMIT_DEPTH; i++) begin
                mem[i] <= 16'h0000;
            end
        end else if (ce_i && en_i && we_i) begin
            for (int b = 0; b < 2; b++) begin
                if (be_i[b]) begin
                    mem[addr_i][b*8 +: 8] <= wdata_i[b*8 +: 8];
                end
            end
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            rdata_o <= 16'h0000;
        end else if (ce_i && en_i && !we_i) begin
            rdata_o <= mem[addr_i];
        end
    end

endmodule

// ---- design/limit_check.sv ----
// One limit comparison: is a result above a high limit or below a low one.
// Assumes both words share the channel's number format.
module limit_check (
    // Operands
    input wire logic [15:0] value_i,
    input wire logic [15:0] limit_i,
    // Comparison mode
    input wire logic high_i,
    input wire logic signed_i,
    // Verdict
    output logic outside_o
);

    logic above;
    logic below;

    always_comb begin
        if (signed_i) begin
            above = $signed(value_i) > $signed(limit_i);
            below = $signed(value_i) < $signed(limit_i);
        end else begin
            above = value_i > limit_i;
            below = value_i < limit_i;
        end
        outside_o = high_i ? above : below;
    end

endmodule

// ---- design/monitor_channel_readout.sv ----
// Five-channel monitor readout: round-robin conversion requests, serial result capture,
// limit checking, sticky flags with interrupt, two open-drain buffers, write protect.
// Assumes an Avalon-MM master on clk_sys_i and a converter that shifts results
// MSB first on a slow link clock, changing data away from the rising edge.
//
// Our own choices: the placing of the registers and the Avalon-MM slave port.
`include "monitor_defs.svh"

module monitor_channel_readout #(
    parameter int unsigned SLOT_CYCLES = `SLOT_CYCLES
) (
    // Clock, reset, enable
    input wire logic clk_sys_i,
    input wire logic rst_i,
    input wire logic ce_i,
    // Avalon-MM slave
    input wire logic [7:0] avs_address_i,
    input wire logic avs_read_i,
    input wire logic avs_write_i,
    input wire logic [31:0] avs_writedata_i,
    input wire logic [3:0] avs_byteenable_i,
    output logic [31:0] avs_readdata_o,
    output logic avs_waitrequest_o,
    // Interrupt
    output logic irq_o,
    // Converter link
    input wire logic adc_clk_i,
    input wire logic adc_frame_i,
    input wire logic adc_data_i,
    output logic conv_start_o,
    output logic [2:0] conv_chan_o,
    // Buffers and protect pin
    input wire logic buffer_in_a_i,
    input wire logic buffer_in_b_i,
    input wire logic write_protect_pin_i,
    output logic buffer_out_a_o,
    output logic buffer_out_a_oe_o,
    output logic buffer_out_b_o,
    output logic buffer_out_b_oe_o
);
    import monitor_pkg::*;

    ////////////////////////////////////////////////////////////////////////////////
    // Pin synchronisers

    logic [5:0] pin_meta;
    logic [5:0] pin_sync;
    logic adc_clk_d;
    logic adc_frame_d;

    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            pin_meta <= 6'h00;
            pin_sync <= 6'h00;
        end else if (ce_i) begin
            pin_meta <= {write_protect_pin_i, buffer_in_b_i, buffer_in_a_i,
                         adc_data_i, adc_frame_i, adc_clk_i};
            pin_sync <= pin_meta;
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            adc_clk_d <= 1'b0;
            adc_frame_d <= 1'b0;
        end else if (ce_i) begin
            adc_clk_d <= pin_sync[0];
            adc_frame_d <= pin_sync[1];
        end
    end

    logic link_rise;
    logic frame_end;
    logic write_locked;
    assign link_rise = pin_sync[0] && !adc_clk_d;
    assign frame_end = adc_frame_d && !pin_sync[1];

    ////////////////////////////////////////////////////////////////////////////////
    // Control register and write protection

    ctrl_t ctrl;
    // Unconnected pin floats high, so protection needs the pin pulled low to lift
    assign write_locked = pin_sync[5] && ctrl.protect_en;

    ////////////////////////////////////////////////////////////////////////////////
    // Round-robin conversion requests

    logic [31:0] slot_cnt;

    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            slot_cnt <= 32'h0000_0000;
            conv_start_o <= 1'b0;
            conv_chan_o <= `CHAN_LAST;
        end else if (ce_i) begin
            conv_start_o <= 1'b0;
            if (ctrl.run) begin
                if (slot_cnt >= SLOT_CYCLES - 1) begin
                    slot_cnt <= 32'h0000_0000;
                    conv_start_o <= 1'b1;
                    conv_chan_o <= (conv_chan_o == `CHAN_LAST) ? `CHAN_TEMP
                                                               : conv_chan_o + 3'h1;
                end else begin
                    slot_cnt <= slot_cnt + 32'h0000_0001;
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Serial result capture

    logic [15:0] shift_reg;
    logic [4:0] bit_cnt;
    logic [15:0] justified;
    logic [15:0] masked;
    logic capture;
    logic [15:0] result_q [`NUM_CH];

    // Short frames land left-justified; bits beyond sixteen are dropped
    assign justified = shift_reg << (`SERIAL_BITS - bit_cnt);
    assign masked = ctrl.low_res ? {justified[15:`LOW_RES_BITS], `LOW_RES_BITS'(0)}
                                 : justified;
    assign capture = frame_end && (bit_cnt != 5'h00);

    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            shift_reg <= 16'h0000;
            bit_cnt <= 5'h00;
        end else if (ce_i) begin
            if (frame_end) begin
                bit_cnt <= 5'h00;
            end else if (pin_sync[1] && link_rise && bit_cnt < `SERIAL_BITS) begin
                shift_reg <= {shift_reg[14:0], pin_sync[2]};
                bit_cnt <= bit_cnt + 5'h01;
            end
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            for (int i = 0; i < `NUM_CH; i++) begin
                result_q[i] <= 16'h0000;
            end
        end else if (ce_i && capture) begin
            result_q[conv_chan_o] <= masked;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Limit checking, one limit per cycle from the store

    chk_state_t chk_state;
    logic [2:0] chk_ch;
    logic [15:0] chk_val;
    logic [2:0] chk_cnt;
    logic [1:0] chk_kind;
    logic outside;
    logic [15:0] lim_rdata;
    logic [3:0][`NUM_CH-1:0] live;

    assign chk_kind = 2'(chk_cnt - 3'h1);

    limit_check u_check (
        .value_i(chk_val),
        .limit_i(lim_rdata),
        .high_i(chk_kind == `LIM_ALARM_HI || chk_kind == `LIM_WARN_HI),
        .signed_i(chk_ch == `CHAN_TEMP),
        .outside_o(outside)
    );

    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            chk_state <= CHK_IDLE;
            chk_ch <= 3'h0;
            chk_val <= 16'h0000;
            chk_cnt <= 3'h0;
        end else if (ce_i) begin
            case (chk_state)
                CHK_IDLE: begin
                    if (capture) begin
                        chk_state <= CHK_RUN;
                        chk_ch <= conv_chan_o;
                        chk_val <= masked;
                        chk_cnt <= 3'h0;
                    end
                end
                CHK_RUN: begin
                    chk_cnt <= chk_cnt + 3'h1;
                    if (chk_cnt == 3'h4) begin
                        chk_state <= CHK_IDLE;
                    end
                end
                default: chk_state <= CHK_IDLE;
            endcase
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            live <= '0;
        end else if (ce_i && chk_state == CHK_RUN && chk_cnt != 3'h0) begin
            live[chk_kind][chk_ch] <= outside;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Sticky events and interrupt

    event_t status;
    event_t mask;
    event_t set_evt;
    event_t clr_evt;
    logic bus_take;
    logic bus_wr;

    always_comb begin
        set_evt = '0;
        if (capture) begin
            set_evt.done[conv_chan_o] = 1'b1;
        end
        if (chk_state == CHK_RUN && chk_cnt != 3'h0 && outside) begin
            set_evt.flag[chk_kind][chk_ch] = 1'b1;
        end
        clr_evt = '0;
        if (bus_wr && avs_address_i == `REG_STATUS) begin
            clr_evt = avs_writedata_i[$bits(event_t)-1:0];
        end
    end

    // A set arriving with its clear survives
    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            status <= `EVENT_RESET;
        end else if (ce_i) begin
            status <= (status & ~clr_evt) | set_evt;
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            irq_o <= 1'b0;
        end else if (ce_i) begin
            irq_o <= |(status & mask);
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Buffers

    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            buffer_out_a_o <= 1'b0;
            buffer_out_a_oe_o <= 1'b0;
            buffer_out_b_o <= 1'b0;
            buffer_out_b_oe_o <= 1'b0;
        end else if (ce_i) begin
            buffer_out_a_o <= 1'b0;
            buffer_out_b_o <= 1'b0;
            // Released (high) is the asserted fault level
            buffer_out_a_oe_o <= !(pin_sync[3] || (ctrl.fault_out_en && |live));
            buffer_out_b_oe_o <= !pin_sync[4];
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Avalon-MM slave

    bus_state_t bus_state;
    logic lim_hit;
    logic res_hit;
    logic [7:0] lim_off;
    logic [7:0] res_off;
    logic [31:0] reg_rdata;
    logic mem_en;
    logic mem_we;
    logic [4:0] mem_addr;

    assign lim_off = avs_address_i - `REG_LIMIT_FIRST;
    assign res_off = avs_address_i - `REG_RESULT_FIRST;
    assign lim_hit = avs_address_i >= `REG_LIMIT_FIRST && avs_address_i <= `REG_LIMIT_LAST
                     && avs_address_i[1:0] == 2'h0;
    assign res_hit = avs_address_i >= `REG_RESULT_FIRST && avs_address_i <= `REG_RESULT_LAST
                     && avs_address_i[1:0] == 2'h0;
    // Limit access waits while the checker owns the store
    assign bus_take = bus_state == BUS_IDLE && (avs_read_i || avs_write_i)
                      && !(lim_hit && chk_state == CHK_RUN);
    assign bus_wr = ce_i && bus_take && avs_write_i;

    always_comb begin
        if (chk_state == CHK_RUN) begin
            mem_en = chk_cnt != 3'h4;
            mem_we = 1'b0;
            mem_addr = {chk_ch[2:0], chk_cnt[1:0]};
        end else begin
            mem_en = bus_take && lim_hit && !(avs_write_i && write_locked);
            mem_we = avs_write_i;
            mem_addr = lim_off[6:2];
        end
    end

    limit_ram u_limits (
        .clk_sys_i(clk_sys_i),
        .rst_i(rst_i),
        .ce_i(ce_i),
        .en_i(mem_en),
        .we_i(mem_we),
        .be_i(avs_byteenable_i[1:0]),
        .addr_i(mem_addr),
        .wdata_i(avs_writedata_i[15:0]),
        .rdata_o(lim_rdata)
    );

    always_comb begin
        if (avs_address_i == `REG_CTRL) begin
            reg_rdata = {28'h0000000, ctrl};
        end else if (avs_address_i == `REG_STATUS) begin
            reg_rdata = {7'h00, status};
        end else if (avs_address_i == `REG_MASK) begin
            reg_rdata = {7'h00, mask};
        end else if (avs_address_i == `REG_LIVE) begin
            reg_rdata = {6'h00, write_locked, live, 5'h00};
        end else if (res_hit) begin
            reg_rdata = {16'h0000, result_q[res_off[4:2]]};
        end else begin
            reg_rdata = 32'h0000_0000;
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            ctrl <= `CTRL_RESET;
            mask <= `EVENT_RESET;
        end else if (bus_wr) begin
            if (avs_address_i == `REG_CTRL && avs_byteenable_i[0] && !write_locked) begin
                ctrl <= avs_writedata_i[3:0];
            end else if (avs_address_i == `REG_MASK) begin
                mask <= avs_writedata_i[$bits(event_t)-1:0];
            end
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            bus_state <= BUS_IDLE;
            avs_readdata_o <= 32'h0000_0000;
            avs_waitrequest_o <= 1'b1;
        end else if (ce_i) begin
            case (bus_state)
                BUS_IDLE: begin
                    if (bus_take && lim_hit) begin
                        bus_state <= BUS_MEM;
                    end else if (bus_take) begin
                        avs_readdata_o <= reg_rdata;
                        avs_waitrequest_o <= 1'b0;
                        bus_state <= BUS_ACK;
                    end
                end
                BUS_MEM: begin
                    avs_readdata_o <= {16'h0000, lim_rdata};
                    avs_waitrequest_o <= 1'b0;
                    bus_state <= BUS_ACK;
                end
                BUS_ACK: begin
                    avs_waitrequest_o <= 1'b1;
                    bus_state <= BUS_IDLE;
                end
                default: bus_state <= BUS_IDLE;
            endcase
        end
    end

endmodule

// ---- tb/conv_model.sv ----
// Converter stand-in: on each start pulse shifts one 16-bit word MSB first.
// Assumes the readout samples rising link edges; data moves on falling ones.
module conv_model (
    // System side
    input wire logic clk_i,
    input wire logic start_i,
    input wire logic [2:0] chan_i,
    input wire logic [4:0][15:0] value_i,
    // Link
    output logic adc_clk_o,
    output logic adc_frame_o,
    output logic adc_data_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [15:0] word;
    initial begin
        adc_clk_o = 1'b0;
        adc_frame_o = 1'b0;
        adc_data_o = 1'b0;
        forever begin
            @(posedge clk_i iff start_i);
            @(posedge clk_i);
            word = value_i[chan_i];
            // Odd offset sets the link at a fixed phase clear of the clk_i edges
            #37 adc_frame_o = 1'b1;
            for (int i = 15; i >= 0; i--) begin
                adc_data_o = word[i];
                #80 adc_clk_o = 1'b1;
                #80 adc_clk_o = 1'b0;
            end
            #80 adc_frame_o = 1'b0;
            // Idle line shows the inverse, never a stale bit
            adc_data_o = ~word[0];
        end
    end
endmodule

// ---- tb/monitor_channel_readout_asserts.sv ----
// Checker: port-level timing of bus answers, conversion rotation and buffers.
// Assumes binding into monitor_channel_readout; SLOT_CYCLES is passed on.
module readout_checker #(
    parameter int unsigned SLOT_CYCLES = 400
) (
    input wire logic clk_sys_i,
    input wire logic rst_i,
    input wire logic avs_read_i,
    input wire logic avs_write_i,
    input wire logic [31:0] avs_readdata_o,
    input wire logic avs_waitrequest_o,
    input wire logic conv_start_o,
    input wire logic [2:0] conv_chan_o,
    input wire logic buffer_in_a_i,
    input wire logic buffer_in_b_i,
    input wire logic buffer_out_a_o,
    input wire logic buffer_out_a_oe_o,
    input wire logic buffer_out_b_o,
    input wire logic buffer_out_b_oe_o
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge clk_sys_i); endclocking
    default disable iff (rst_i);
    logic start_d;
    logic had_start;
    logic [2:0] seen_chan;
    int unsigned gap;
    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            start_d <= 1'b0;
            had_start <= 1'b0;
            seen_chan <= 3'h4;
            gap <= 0;
        end else begin
            start_d <= conv_start_o;
            had_start <= had_start | conv_start_o;
            seen_chan <= start_d ? conv_chan_o : seen_chan;
            gap <= conv_start_o ? 0 : gap + 1;
        end
    end
    AST_WAIT_ONE: assert property (!avs_waitrequest_o |=> avs_waitrequest_o)
        else $error("waitrequest low for more than one cycle");
    AST_ANSWER_CAUSE: assert property (!avs_waitrequest_o |-> $past(avs_read_i || avs_write_i))
        else $error("answer without request");
    AST_ANSWER_BOUND: assert property ((avs_read_i || avs_write_i) |-> ##[0:10] !avs_waitrequest_o)
        else $error("bus request not answered in time");
    AST_RDATA_HOLD: assert property ($changed(avs_readdata_o) |-> !avs_waitrequest_o)
        else $error("read data moved outside an answer");
    AST_START_PULSE: assert property (conv_start_o |=> !conv_start_o)
        else $error("start pulse longer than one cycle");
    AST_CHAN_ROTATE: assert property (start_d |->
        conv_chan_o == (seen_chan == 3'h4 ? 3'h0 : seen_chan + 3'h1))
        else $error("channel rotation out of order");
    AST_SLOT_GAP: assert property (conv_start_o && had_start |-> gap == SLOT_CYCLES - 1)
        else $error("start spacing wrong");
    AST_BUF_A_HIGH: assert property (buffer_in_a_i [*5] |-> !buffer_out_a_oe_o)
        else $error("buffer a pulls low with input high");
    AST_BUF_B: assert property ($stable(buffer_in_b_i) [*5] |->
        buffer_out_b_oe_o == !buffer_in_b_i)
        else $error("buffer b does not follow input");
    AST_OD_DATA: assert property (!buffer_out_a_o && !buffer_out_b_o)
        else $error("open-drain data not low");
    cover property (conv_start_o && conv_chan_o == 3'h4);
    cover property (!buffer_in_a_i && !buffer_out_a_oe_o);
    cover property (!avs_waitrequest_o && avs_write_i);
endmodule
bind monitor_channel_readout readout_checker #(.SLOT_CYCLES(SLOT_CYCLES)) readout_checker_i (
    .clk_sys_i, .rst_i, .avs_read_i, .avs_write_i, .avs_readdata_o, .avs_waitrequest_o,
    .conv_start_o, .conv_chan_o, .buffer_in_a_i, .buffer_in_b_i, .buffer_out_a_o,
    .buffer_out_a_oe_o, .buffer_out_b_o, .buffer_out_b_oe_o);

// ---- tb/monitor_channel_readout_tb.sv ----
// Testbench of the monitor readout: Avalon master tasks and one task per scenario.
// Assumes the design, the converter model and the checker are compiled first.
`include "monitor_defs.svh"
module monitor_channel_readout_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import monitor_pkg::*;
    localparam int unsigned SLOT = 400;
    logic clk_sys_i = 1'b0;
    logic rst_i = 1'b1;
    logic [7:0] avs_address_i = 8'h00;
    logic avs_read_i = 1'b0;
    logic avs_write_i = 1'b0;
    logic [31:0] avs_writedata_i = 32'h0;
    logic buffer_in_a_i = 1'b0;
    logic buffer_in_b_i = 1'b0;
    logic write_protect_pin_i = 1'b1;
    logic [31:0] avs_readdata_o, q;
    logic avs_waitrequest_o, irq_o, adc_clk_i, adc_frame_i, adc_data_i, conv_start_o;
    logic buffer_out_a_o, buffer_out_a_oe_o, buffer_out_b_o, buffer_out_b_oe_o;
    logic [2:0] conv_chan_o;
    logic [4:0][15:0] value = {16'h7FFC, 16'h0000, 16'hABCF, 16'hFFF8, 16'h8000};
    int mismatches = 0;
    int n_compared = 0;
    always #5 clk_sys_i = ~clk_sys_i;
    monitor_channel_readout #(.SLOT_CYCLES(SLOT)) monitor_channel_readout_i (
        .clk_sys_i, .rst_i, .ce_i(1'b1), .avs_address_i, .avs_read_i, .avs_write_i,
        .avs_writedata_i, .avs_byteenable_i(4'hF), .avs_readdata_o, .avs_waitrequest_o,
        .irq_o, .adc_clk_i, .adc_frame_i, .adc_data_i, .conv_start_o, .conv_chan_o,
        .buffer_in_a_i, .buffer_in_b_i, .write_protect_pin_i, .buffer_out_a_o,
        .buffer_out_a_oe_o, .buffer_out_b_o, .buffer_out_b_oe_o);
    conv_model conv_model_i (.clk_i(clk_sys_i), .start_i(conv_start_o), .chan_i(conv_chan_o),
        .value_i(value), .adc_clk_o(adc_clk_i), .adc_frame_o(adc_frame_i),
        .adc_data_o(adc_data_i));
    ////////////////////////////////////////////////////////////////////////////////
    task automatic close_out();
        $display("compared %0d mismatches %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        n_compared++;
        if (got !== exp) begin
            mismatches++;
            $display("wrong value %s expected %h seen %h", name, exp, got);
        end
    endtask
    // Request held until waitrequest is sampled low, released at that edge
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_sys_i);
        avs_address_i <= a;
        avs_writedata_i <= d;
        avs_write_i <= wr;
        avs_read_i <= !wr;
        // No cycle count assumed: only the watchdog ends this wait
        do begin
            @(posedge clk_sys_i);
        end while (avs_waitrequest_o !== 1'b0);
        q = avs_readdata_o;
        avs_read_i <= 1'b0;
        avs_write_i <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] exp, input string name);
        bus(1'b0, a, 32'h0);
        chk(name, exp, q);
    endtask
    // Channel output changes only at a start, so a change to ch marks its start
    task automatic wait_chan(input logic [2:0] ch);
        int n;
        n = 0;
        while (conv_chan_o === ch && n < 3000) begin
            @(posedge clk_sys_i);
            n++;
        end
        while (conv_chan_o !== ch && n < 3000) begin
            @(posedge clk_sys_i);
            n++;
        end
        if (n >= 3000) mismatches++;
    endtask
    task automatic round();
        wait_chan(3'h0);
        wait_chan(3'h0);
        repeat (320) @(posedge clk_sys_i);
    endtask
    task automatic pins(input logic a, input logic b, input logic p);
        @(posedge clk_sys_i);
        buffer_in_a_i <= a;
        buffer_in_b_i <= b;
        write_protect_pin_i <= p;
        repeat (6) @(posedge clk_sys_i);
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    task automatic t_reset();
        rd(`REG_CTRL, 32'h1, "ctrl");
        rd(`REG_STATUS, 32'h0, "status");
        rd(`REG_MASK, 32'h0, "mask");
        rd(8'h30, 32'h0, "unmapped");
    endtask
    task automatic t_results();
        bus(1'b1, `REG_STATUS, 32'h01FFFFFF);
        round();
        for (int c = 0; c < 5; c++) begin
            rd(`REG_RESULT_FIRST + 8'(c * 4), {16'h0, value[c]}, "result");
        end
        // Host-side scaling: counts to microvolts, nanovolts and whole degrees
        rd(8'h14, 32'hFFF8, "supply");
        chk("supply uv", 32'd6552800, q[15:0] * 32'd100);
        rd(8'h18, 32'hABCF, "ext a");
        chk("ext a nv", 32'd1677247296, (q[15:0] & 16'hFFF0) * 32'd38147);
        rd(8'h10, 32'h8000, "temp");
        chk("temp deg", 32'hFFFFFF80, 32'($signed(q[15:8])));
        bus(1'b0, `REG_STATUS, 32'h0);
        chk("done", 32'h1F, q & 32'h1F);
    endtask
    task automatic t_limits();
        for (int c = 0; c < 5; c++) begin
            for (int k = 0; k < 4; k++) begin
                bus(1'b1, `REG_LIMIT_FIRST + 8'(c * 16 + k * 4),
                    (k % 2 == 0) ? (c == 0 ? 32'h7FFF : 32'hFFFF) : (c == 0 ? 32'h8000 : 32'h0));
            end
        end
        bus(1'b1, 8'h50, 32'hFFF0);
        bus(1'b1, 8'h44, 32'h8001);
        bus(1'b1, 8'h88, 32'h7FFB);
        bus(1'b1, 8'h6C, 32'hB000);
        round();
        bus(1'b1, `REG_STATUS, 32'h01FFFFFF);
        round();
        rd(`REG_STATUS, 32'h0048045F, "status");
        rd(`REG_LIVE, 32'h00480440, "live");
        chk("irq", 32'h0, {31'h0, irq_o});
    endtask
    task automatic t_irq();
        bus(1'b1, `REG_MASK, 32'h80);
        repeat (2) @(posedge clk_sys_i);
        chk("irq", 32'h0, {31'h0, irq_o});
        bus(1'b1, `REG_MASK, 32'h40);
        repeat (2) @(posedge clk_sys_i);
        chk("irq", 32'h1, {31'h0, irq_o});
        wait_chan(3'h3);
        bus(1'b1, `REG_STATUS, 32'h40);
        repeat (2) @(posedge clk_sys_i);
        chk("irq", 32'h0, {31'h0, irq_o});
        bus(1'b1, `REG_MASK, 32'h0);
    endtask
    task automatic t_buffers();
        bus(1'b1, `REG_CTRL, 32'h5);
        pins(1'b0, 1'b1, 1'b1);
        chk("oe a", 32'h0, {31'h0, buffer_out_a_oe_o});
        chk("oe b", 32'h0, {31'h0, buffer_out_b_oe_o});
        bus(1'b1, `REG_CTRL, 32'h1);
        pins(1'b0, 1'b0, 1'b1);
        chk("oe a", 32'h1, {31'h0, buffer_out_a_oe_o});
        chk("oe b", 32'h1, {31'h0, buffer_out_b_oe_o});
        pins(1'b1, 1'b0, 1'b1);
        chk("oe a", 32'h0, {31'h0, buffer_out_a_oe_o});
    endtask
    task automatic t_protect();
        bus(1'b1, `REG_CTRL, 32'h9);
        rd(`REG_LIVE, 32'h02480440, "live");
        bus(1'b1, `REG_CTRL, 32'h1);
        bus(1'b1, 8'h50, 32'h0);
        rd(`REG_CTRL, 32'h9, "ctrl");
        rd(8'h50, 32'hFFF0, "limit");
        pins(1'b1, 1'b0, 1'b0);
        bus(1'b1, `REG_CTRL, 32'h1);
        rd(`REG_CTRL, 32'h1, "ctrl");
    endtask
    task automatic t_low_res();
        bus(1'b1, `REG_CTRL, 32'h3);
        round();
        rd(8'h18, 32'hABC8, "result");
        rd(8'h20, 32'h7FF8, "result");
        rd(8'h10, 32'h8000, "result");
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (40000) @(posedge clk_sys_i);
        mismatches++;
        close_out();
    end
    initial begin
        repeat (6) @(posedge clk_sys_i);
        rst_i <= 1'b0;
        t_reset();
        t_results();
        t_limits();
        t_irq();
        t_buffers();
        t_protect();
        t_low_res();
        close_out();
    end
endmodule
